// ==== rtl/sdw_pkg.sv ====
// constants for the sampling delay and reference-pulse window block
package sdw_pkg;
	// register offsets
	localparam logic [7:0] ADDR_DELAY = 8'h00;
	localparam logic [7:0] ADDR_RAMP = 8'h04;
	localparam logic [7:0] ADDR_REFSEL = 8'h08;
	localparam logic [7:0] ADDR_MAP = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_APPLIED = 8'h14;
	// delay register fields
	localparam int FINE_LSB = 0;
	localparam int COARSE_LSB = 8;
	localparam int INV_BIT = 16;
	localparam int CODE_W = 8;
	// ramp register fields
	localparam int RAMP_EN_BIT = 0;
	localparam int RAMP_FAST_BIT = 1;
	// refsel register fields
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int STEP_FINE_BIT = 8;
	localparam int SINGLE_CH_BIT = 9;
	// status fields
	localparam int MAP_VALID_BIT = 0;
	localparam int RAMP_BUSY_BIT = 1;
	// map and ramp figures
	localparam int MAP_W = 24;
	localparam int MIN_EDGES = 3;
	localparam int RAMP_PERIOD = 256;
	localparam int SLOW_STEPS = 1;
	localparam int FAST_STEPS = 4;
	// reset values, unmapped read value and ramp states
	localparam logic [7:0] COARSE_RESET = 8'h00;
	localparam logic [7:0] FINE_RESET = 8'h00;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic STEP_FINE_RESET = 1'b1;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [1:0] {SDW_IDLE, SDW_RAMP} sdw_ramp_state_t;
endpackage

// ==== rtl/sdw_phase_cell.sv ====
// one detector position: records setup or hold risk for a delayed reference sample
`timescale 1ns/1ps
module sdw_phase_cell (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clear_i,
	input wire logic early_i,
	input wire logic late_i,
	input wire logic edge_i,
	output logic risk_o
);
	logic next_risk;
	always_comb
	begin
		next_risk = risk_o;
		if (edge_i && (early_i != late_i))
		begin
			next_risk = 1'b1;
		end
		else if (clear_i)
		begin
			next_risk = 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			risk_o <= 1'b0;
		end
		else
		begin
			risk_o <= next_risk;
		end
	end
endmodule // sdw_phase_cell

// ==== rtl/sdw_top.sv ====
// sampling delay control, coarse ramp, reference-pulse position map and select
`timescale 1ns/1ps
module sdw_top #(
	parameter int MAP_W = sdw_pkg::MAP_W,
	parameter int RAMP_PERIOD = sdw_pkg::RAMP_PERIOD
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic refpulse_i,
	input wire logic [MAP_W-1:0] tap_early_i,
	input wire logic [MAP_W-1:0] tap_late_i,
	output logic clock_invert_delay_o,
	output logic [7:0] coarse_delay_code_o,
	output logic [7:0] fine_delay_code_o,
	output logic refpulse_step_fine_o,
	output logic dual_edge_o,
	output logic [3:0] refpulse_sample_choice_o,
	output logic refpulse_captured_o
);
	localparam int CW = sdw_pkg::CODE_W;
	localparam int RCW = $clog2(RAMP_PERIOD);
	// software state
	logic inv;
	logic [CW-1:0] target;
	logic [CW-1:0] fine;
	logic ramp_enable_bit;
	logic ramp_speed_select;
	logic [3:0] sel;
	logic step_fine;
	logic single_ch;
	logic next_inv;
	logic [CW-1:0] next_target;
	logic [CW-1:0] next_fine;
	logic next_ramp_en;
	logic next_ramp_fast;
	logic [3:0] next_sel;
	logic next_step_fine;
	logic next_single_ch;
	logic coarse_wr;
	assign coarse_wr = wr_i && (addr_i == sdw_pkg::ADDR_DELAY);
	always_comb
	begin
		next_inv = inv;
		next_target = target;
		next_fine = fine;
		next_ramp_en = ramp_enable_bit;
		next_ramp_fast = ramp_speed_select;
		next_sel = sel;
		next_step_fine = step_fine;
		next_single_ch = single_ch;
		if (coarse_wr)
		begin
			next_inv = wdata_i[sdw_pkg::INV_BIT];
			next_target = wdata_i[sdw_pkg::COARSE_LSB +: CW];
			next_fine = wdata_i[sdw_pkg::FINE_LSB +: CW];
		end
		if (wr_i && (addr_i == sdw_pkg::ADDR_RAMP))
		begin
			next_ramp_en = wdata_i[sdw_pkg::RAMP_EN_BIT];
			next_ramp_fast = wdata_i[sdw_pkg::RAMP_FAST_BIT];
		end
		if (wr_i && (addr_i == sdw_pkg::ADDR_REFSEL))
		begin
			next_sel = wdata_i[sdw_pkg::SEL_LSB +: sdw_pkg::SEL_W];
			next_step_fine = wdata_i[sdw_pkg::STEP_FINE_BIT];
			next_single_ch = wdata_i[sdw_pkg::SINGLE_CH_BIT];
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			inv <= 1'b0;
			target <= sdw_pkg::COARSE_RESET;
			fine <= sdw_pkg::FINE_RESET;
			ramp_enable_bit <= 1'b0;
			ramp_speed_select <= 1'b0;
			sel <= sdw_pkg::SEL_RESET;
			step_fine <= sdw_pkg::STEP_FINE_RESET;
			single_ch <= 1'b0;
		end
		else
		begin
			inv <= next_inv;
			target <= next_target;
			fine <= next_fine;
			ramp_enable_bit <= next_ramp_en;
			ramp_speed_select <= next_ramp_fast;
			sel <= next_sel;
			step_fine <= next_step_fine;
			single_ch <= next_single_ch;
		end
	end
	// coarse ramp engine
	sdw_pkg::sdw_ramp_state_t state;
	sdw_pkg::sdw_ramp_state_t next_state;
	logic [CW-1:0] applied;
	logic [CW-1:0] next_applied;
	logic [RCW-1:0] tick;
	logic [RCW-1:0] next_tick;
	logic [CW:0] step;
	logic [CW:0] diff;
	localparam logic [RCW-1:0] QUARTER = RCW'(RAMP_PERIOD / sdw_pkg::FAST_STEPS);
	always_comb
	begin
		next_state = state;
		next_applied = applied;
		next_tick = tick + 1'b1;
		step = (CW+1)'(sdw_pkg::SLOW_STEPS);
		diff = (target > applied) ? {1'b0, target - applied} : {1'b0, applied - target};
		unique case (state)
			sdw_pkg::SDW_IDLE:
			begin
				next_tick = '0;
				if (applied != target)
				begin
					if (ramp_enable_bit)
					begin
						next_state = sdw_pkg::SDW_RAMP;
					end
					else
					begin
						next_applied = target;
					end
				end
			end
			sdw_pkg::SDW_RAMP:
			begin
				// fast rate spreads four steps evenly over the period
				if ((ramp_speed_select && (tick % QUARTER == QUARTER - 1'b1))
					|| (tick == RCW'(RAMP_PERIOD - 1)))
				begin
					step = (diff < step) ? diff : step;
					next_applied = (target > applied) ? applied + step[CW-1:0]
						: applied - step[CW-1:0];
				end
				if (!ramp_enable_bit)
				begin
					next_applied = target;
					next_state = sdw_pkg::SDW_IDLE;
				end
				else if (coarse_wr)
				begin
					next_tick = '0;
				end
				else if (next_applied == target)
				begin
					next_state = sdw_pkg::SDW_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= sdw_pkg::SDW_IDLE;
			applied <= sdw_pkg::COARSE_RESET;
			tick <= '0;
		end
		else
		begin
			state <= next_state;
			applied <= next_applied;
			tick <= next_tick;
		end
	end
	// reference pulse synchroniser and edge count
	logic [1:0] ref_sync;
	logic ref_last;
	logic [1:0] edges;
	logic [1:0] next_edges;
	logic ref_rise;
	logic [MAP_W-1:0] early_s1;
	logic [MAP_W-1:0] early_s2;
	logic [MAP_W-1:0] late_s1;
	logic [MAP_W-1:0] late_s2;
	logic [MAP_W-1:0] risk;
	logic map_clear;
	assign ref_rise = ref_sync[1] && !ref_last;
	assign map_clear = wr_i && (addr_i == sdw_pkg::ADDR_MAP);
	always_comb
	begin
		next_edges = edges;
		if (map_clear)
		begin
			next_edges = '0;
		end
		// an edge in the clearing cycle still counts
		if (ref_rise && (map_clear || (edges != 2'(sdw_pkg::MIN_EDGES))))
		begin
			next_edges = next_edges + 1'b1;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ref_sync <= '0;
			ref_last <= 1'b0;
			edges <= '0;
			early_s1 <= '0;
			early_s2 <= '0;
			late_s1 <= '0;
			late_s2 <= '0;
		end
		else
		begin
			ref_sync <= {ref_sync[0], refpulse_i};
			ref_last <= ref_sync[1];
			edges <= next_edges;
			early_s1 <= tap_early_i;
			early_s2 <= early_s1;
			late_s1 <= tap_late_i;
			late_s2 <= late_s1;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < MAP_W; gi++)
		begin : g_cell
			sdw_phase_cell u_cell (
				.clk_i(clk_i),
				.rst_b_i(rst_b_i),
				.clear_i(map_clear),
				.early_i(early_s2[gi]),
				.late_i(late_s2[gi]),
				.edge_i(ref_rise),
				.risk_o(risk[gi])
			);
		end
	endgenerate
	logic [MAP_W-1:0] phase_map;
	logic map_valid;
	always_comb
	begin
		phase_map = risk;
		phase_map[0] = 1'b1;
		phase_map[MAP_W-1] = 1'b1;
	end
	assign map_valid = (edges == 2'(sdw_pkg::MIN_EDGES));
	// selected position capture of the reference pulse
	logic captured;
	logic next_captured;
	always_comb
	begin
		next_captured = captured;
		if (ref_rise && !phase_map[sel])
		begin
			next_captured = 1'b1;
		end
		else if (!ref_sync[1])
		begin
			next_captured = 1'b0;
		end
	end
	// read port
	logic [31:0] next_rdata;
	always_comb
	begin
		next_rdata = sdw_pkg::UNMAPPED_READ;
		if (rd_i)
		begin
			unique case (addr_i)
				sdw_pkg::ADDR_DELAY:
					next_rdata = {15'h0000, inv, target, fine};
				sdw_pkg::ADDR_RAMP:
					next_rdata = {30'h0000_0000, ramp_speed_select, ramp_enable_bit};
				sdw_pkg::ADDR_REFSEL:
					next_rdata = {22'h00_0000, single_ch, step_fine, 4'h0, sel};
				sdw_pkg::ADDR_MAP:
					next_rdata = {{(32-MAP_W){1'b0}}, phase_map};
				sdw_pkg::ADDR_STATUS:
					next_rdata = {30'h0000_0000, state == sdw_pkg::SDW_RAMP, map_valid};
				sdw_pkg::ADDR_APPLIED:
					next_rdata = {24'h00_0000, applied};
				default:
					next_rdata = sdw_pkg::UNMAPPED_READ;
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rdata_o <= '0;
			captured <= 1'b0;
		end
		else
		begin
			rdata_o <= next_rdata;
			captured <= next_captured;
		end
	end
	// delay controls to the analog clock path, plus the reference select and capture outputs
	assign clock_invert_delay_o = inv;
	assign coarse_delay_code_o = applied;
	assign fine_delay_code_o = fine;
	assign refpulse_step_fine_o = step_fine;
	assign dual_edge_o = single_ch;
	assign refpulse_sample_choice_o = sel;
	assign refpulse_captured_o = captured;
endmodule // sdw_top

// ==== verification/sdw_top_assertions.sv ====
// port checker for the sampling delay and reference window block
`timescale 1ns/1ps
module sdw_top_assertions #(
	parameter int MAP_W = 24
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic refpulse_i,
	input wire logic clock_invert_delay_o,
	input wire logic [7:0] coarse_delay_code_o,
	input wire logic [7:0] fine_delay_code_o,
	input wire logic refpulse_step_fine_o,
	input wire logic dual_edge_o,
	input wire logic [3:0] refpulse_sample_choice_o,
	input wire logic refpulse_captured_o
);
	logic dw;
	logic sw;
	logic rw;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	assign dw = wr_i && addr_i == sdw_pkg::ADDR_DELAY;
	assign sw = wr_i && addr_i == sdw_pkg::ADDR_REFSEL;
	assign rw = wr_i && addr_i == sdw_pkg::ADDR_RAMP;
	fine_write_a: assert property (dw |=> fine_delay_code_o == $past(wdata_i[7:0]))
		else $error("fine code not taken");
	invert_write_a: assert property (dw |=> clock_invert_delay_o == $past(wdata_i[16]))
		else $error("inversion not taken");
	fine_hold_a: assert property (!dw |=> $stable(fine_delay_code_o))
		else $error("fine code moved without write");
	refsel_write_a: assert property (sw |=> {dual_edge_o, refpulse_step_fine_o,
		refpulse_sample_choice_o} == $past({wdata_i[9:8], wdata_i[3:0]}))
		else $error("select fields not taken");
	coarse_step_a: assert property (!(dw || rw || $past(dw) || $past(rw)) |=>
		(coarse_delay_code_o - $past(coarse_delay_code_o)) inside {8'h00, 8'h01, 8'hFF})
		else $error("coarse code jumped");
	map_edges_a: assert property (rd_i && addr_i == sdw_pkg::ADDR_MAP |=> rdata_o[0]
		&& rdata_o[MAP_W-1])
		else $error("map end bits clear");
	applied_read_a: assert property (rd_i && addr_i == sdw_pkg::ADDR_APPLIED |=>
		rdata_o == {24'h00_0000, $past(coarse_delay_code_o)})
		else $error("applied code readback wrong");
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data outside read slot");
	capture_clear_a: assert property (!refpulse_i [*4] |-> !refpulse_captured_o)
		else $error("capture flag held without pulse");
endmodule // sdw_top_assertions

// ==== verification/sdw_refgen.sv ====
// clock generator side model: reference pulses and detector taps
`timescale 1ns/1ps
module sdw_refgen (
	input wire logic clk_i,
	input wire logic [7:0] count_i,
	input wire logic start_i,
	input wire logic [23:0] risk_i,
	output logic refpulse_o,
	output logic [23:0] tap_early_o,
	output logic [23:0] tap_late_o,
	output logic busy_o
);
	assign tap_early_o = {24{refpulse_o}};
	assign tap_late_o = tap_early_o ^ risk_i;
	initial
	begin
		refpulse_o = 1'b0;
		busy_o = 1'b0;
		forever
		begin
			@(negedge clk_i);
			if (start_i)
			begin
				busy_o = 1'b1;
				repeat (count_i)
				begin
					refpulse_o = 1'b1;
					repeat (6) @(negedge clk_i);
					refpulse_o = 1'b0;
					repeat (6) @(negedge clk_i);
				end
				busy_o = 1'b0;
			end
		end
	end
endmodule // sdw_refgen

// ==== verification/sdw_top_tb.sv ====
// self-checking bench for the sampling delay and reference window block
`timescale 1ns/1ps
module sdw_top_tb;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [22:0] e;} sdw_row_t;
	logic clk_i, rst_b_i, wr_i, rd_i, refpulse_i, clock_invert_delay_o;
	logic refpulse_step_fine_o, dual_edge_o, refpulse_captured_o, start, busy, cap_seen;
	logic [7:0] addr_i, coarse_delay_code_o, fine_delay_code_o, cnt;
	logic [31:0] wdata_i, rdata_o, r;
	logic [23:0] tap_early_i, tap_late_i, risk;
	logic [3:0] refpulse_sample_choice_o;
	int miscompares, comparisons, n;
	sdw_row_t rows [5] = '{
		'{sdw_pkg::ADDR_DELAY, 32'h0001_FF00, 23'h7F_C020},
		'{sdw_pkg::ADDR_DELAY, 32'h0000_00FF, 23'h00_3FE0},
		'{sdw_pkg::ADDR_REFSEL, 32'h0000_000F, 23'h00_3FCF},
		'{sdw_pkg::ADDR_REFSEL, 32'h0000_0300, 23'h00_3FF0},
		'{sdw_pkg::ADDR_DELAY, 32'h0001_2A5C, 23'h4A_9730}};
	sdw_top i_dut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .refpulse_i,
		.tap_early_i, .tap_late_i, .clock_invert_delay_o, .coarse_delay_code_o,
		.fine_delay_code_o, .refpulse_step_fine_o, .dual_edge_o, .refpulse_sample_choice_o,
		.refpulse_captured_o);
	sdw_refgen i_gen (.clk_i, .count_i(cnt), .start_i(start), .risk_i(risk),
		.refpulse_o(refpulse_i), .tap_early_o(tap_early_i), .tap_late_o(tap_late_i),
		.busy_o(busy));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (refpulse_captured_o === 1'b1) cap_seen <= 1'b1;
	function automatic logic [31:0] obs();
		return {9'h000, clock_invert_delay_o, coarse_delay_code_o, fine_delay_code_o,
			refpulse_step_fine_o, dual_edge_o, refpulse_sample_choice_o};
	endfunction
	task automatic print_verdict();
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 r = rdata_o;
		@(posedge clk_i);
	endtask
	task automatic pulses(input logic [7:0] k);
		cnt <= k;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		for (n = 0; busy !== 1'b0 && n < 4000; n++) @(posedge clk_i);
		if (n == 4000) chk(32'h0000_0001, 32'h0000_0000, "pulse timeout");
		if (n == 4000) print_verdict();
		repeat (4) @(posedge clk_i);
	endtask
	task automatic wait_co(input logic [7:0] t);
		for (n = 0; coarse_delay_code_o !== t && n < 1000; n++) @(posedge clk_i);
		if (n == 1000) chk(32'h0000_0001, 32'h0000_0000, "ramp timeout");
		if (n == 1000) print_verdict();
	endtask
	initial
	begin
		{wr_i, rd_i, start, cap_seen} = 4'h0;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		cnt = 8'h00;
		risk = 24'h00_0000;
		rst_b_i = 1'b0;
		repeat (4) @(posedge clk_i);
		chk(obs(), 32'h0000_0020, "reset values");
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			@(posedge clk_i);
			chk(obs(), {9'h000, rows[i].e}, "control outputs");
		end
		rd(8'h20);
		chk(r, 32'h0000_0000, "unmapped read");
		$display("register rows done");
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_0000);
		wr(sdw_pkg::ADDR_RAMP, 32'h0000_0001);
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_0200);
		chk(obs(), 32'h0000_0030, "coarse jumped with ramp");
		wait_co(8'h02);
		chk(32'(n >= 500 && n <= 520), 32'h0000_0001, "slow ramp rate");
		rd(sdw_pkg::ADDR_APPLIED);
		chk(r, 32'h0000_0002, "applied code");
		wr(sdw_pkg::ADDR_RAMP, 32'h0000_0003);
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_0600);
		wait_co(8'h06);
		chk(32'(n >= 240 && n <= 270), 32'h0000_0001, "fast ramp rate");
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_0800);
		repeat (100) @(posedge clk_i);
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_0400);
		wait_co(8'h04);
		chk(32'(n >= 185 && n <= 200), 32'h0000_0001, "ramp not restarted");
		wr(sdw_pkg::ADDR_RAMP, 32'h0000_0000);
		wr(sdw_pkg::ADDR_DELAY, 32'h0000_4000);
		@(posedge clk_i);
		chk({24'h00_0000, coarse_delay_code_o}, 32'h0000_0040, "direct coarse");
		$display("ramp tests done");
		wr(sdw_pkg::ADDR_MAP, 32'h0000_0000);
		risk <= 24'h00_0020;
		wr(sdw_pkg::ADDR_REFSEL, 32'h0000_0105);
		pulses(8'h02);
		rd(sdw_pkg::ADDR_STATUS);
		chk(r & 32'h0000_0001, 32'h0000_0000, "map valid early");
		cap_seen <= 1'b0;
		pulses(8'h01);
		rd(sdw_pkg::ADDR_STATUS);
		chk(r & 32'h0000_0001, 32'h0000_0001, "map not valid");
		rd(sdw_pkg::ADDR_MAP);
		chk(r, 32'h0080_0021, "position map");
		chk({31'h0000_0000, cap_seen}, 32'h0000_0000, "captured at risky slot");
		wr(sdw_pkg::ADDR_REFSEL, 32'h0000_0102);
		cap_seen <= 1'b0;
		pulses(8'h01);
		chk({31'h0000_0000, cap_seen}, 32'h0000_0001, "no capture at safe slot");
		$display("map tests done");
		print_verdict();
	end
endmodule // sdw_top_tb
bind sdw_top sdw_top_assertions #(.MAP_W(MAP_W)) i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.refpulse_i(refpulse_i), .clock_invert_delay_o(clock_invert_delay_o),
	.coarse_delay_code_o(coarse_delay_code_o), .fine_delay_code_o(fine_delay_code_o),
	.refpulse_step_fine_o(refpulse_step_fine_o), .dual_edge_o(dual_edge_o),
	.refpulse_sample_choice_o(refpulse_sample_choice_o),
	.refpulse_captured_o(refpulse_captured_o));
